// [design/tcsc_pkg.sv]
// What this block does
// - clock-enable bit 0 low stops the timer unit clock, high supplies it
// - first operation clock is source clock divided by 2^(bits 3:0)
// - prescale register also holds fields at 7:4, 9:8, 13:12; rest read zero
// - writing 1 to channel 0 stop bit halts counting; writing 0 does nothing
// - stop register has bits 7:0 per channel plus bits 9 and 11; rest zero
// - mode field picks interval, capture, event, one-count, capture+one
// - one-count 1000 ignores start while counting; 1001 accepts restart
// - mode fields at 15:14, 12, 11, 10:8, 7:6, 3:0; bits 13, 5, 4 zero
// - edge select: falling, rising, both for low width, both for high width
// - trigger select: software only, valid edge, both edges, master interrupt
// - start clears counter in capture modes, loads data otherwise; capture edge copies, interrupts, clears counter
package tcsc_pkg;
	localparam int ADR_W = 8;
	// register byte offsets
	localparam logic [ADR_W-1:0] OFS_GATE = 8'h00;
	localparam logic [ADR_W-1:0] OFS_PRESC = 8'h04;
	localparam logic [ADR_W-1:0] OFS_START = 8'h08;
	localparam logic [ADR_W-1:0] OFS_STOP = 8'h0C;
	localparam logic [ADR_W-1:0] OFS_MODE = 8'h10;
	localparam logic [ADR_W-1:0] OFS_COUNT = 8'h14;
	localparam logic [ADR_W-1:0] OFS_DATA = 8'h18;
	localparam logic [ADR_W-1:0] OFS_STATUS = 8'h1C;
	// writable bit masks, all other bits read zero
	localparam logic [7:0] GATE_MASK = 8'hBD;
	localparam logic [15:0] PRESC_MASK = 16'h33FF;
	localparam logic [15:0] STOP_MASK = 16'h0AFF;
	localparam logic [15:0] MODE_MASK = 16'hDFCF;
	// reset values
	localparam logic [7:0] GATE_RST = 8'h00;
	localparam logic [15:0] PRESC_RST = 16'h0000;
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] DATA_RST = 16'h0000;
	// field positions
	localparam int GATE_EN_BIT = 0;
	localparam int CH0_BIT = 0;
	localparam int PRSA_LO = 0;
	localparam int PRSB_LO = 4;
	localparam int MODE_LO = 0;
	localparam int EDGE_LO = 6;
	localparam int TRIG_LO = 8;
	localparam int CCS_BIT = 12;
	localparam int CKS_HI = 15;
	// channel mode codes
	localparam logic [3:0] MD_INT0 = 4'h0;
	localparam logic [3:0] MD_INT1 = 4'h1;
	localparam logic [3:0] MD_CAP0 = 4'h4;
	localparam logic [3:0] MD_CAP1 = 4'h5;
	localparam logic [3:0] MD_EVT = 4'h6;
	localparam logic [3:0] MD_ONE0 = 4'h8;
	localparam logic [3:0] MD_ONE1 = 4'h9;
	localparam logic [3:0] MD_CAPONE = 4'hC;
	// edge and trigger codes
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [2:0] TRIG_SW = 3'h0;
	localparam logic [2:0] TRIG_EDGE = 3'h1;
	localparam logic [2:0] TRIG_BOTH = 3'h2;
	localparam logic [2:0] TRIG_MASTER = 3'h4;
	typedef enum logic [1:0] {CH_OFF, CH_WAIT, CH_RUN} tcsc_ch_t;
	typedef enum logic [2:0] {
		FN_INTERVAL, FN_CAPTURE, FN_EVENT, FN_ONE, FN_CAPONE
	} tcsc_fn_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [ADR_W-1:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} tcsc_wb_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} tcsc_wb_rsp_t;
endpackage

// [design/tcsc_top.sv]
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tcsc_top (
	input wire logic mclk,
	input wire logic nrst,
	input wire tcsc_pkg::tcsc_wb_req_t wb_req,
	output tcsc_pkg::tcsc_wb_rsp_t wb_rsp,
	input wire logic capture_input_pin,
	input wire logic master_irq_in,
	output logic timer_unit_clock_enable,
	output logic ch0_timer_irq,
	output logic [15:0] stop_trigger_pulse
);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [7:0] gate;
		logic [15:0] presc_sel;
		logic [15:0] mode;
		logic [15:0] data;
		logic [15:0] cnt;
		logic [14:0] presc;
		tcsc_pkg::tcsc_ch_t ch;
		logic irq;
		logic [15:0] stop_pulse;
		logic pin_s1;
		logic pin_s2;
		logic pin_prev;
	} tcsc_state_t;

	tcsc_state_t q;
	tcsc_state_t next_q;

	logic gate_on;
	logic bus_req;
	logic wr;
	logic [15:0] be16;
	logic [3:0] prs_a;
	logic [3:0] prs_b;
	logic [14:0] mask_a;
	logic [14:0] mask_b;
	logic tick_a;
	logic tick_b;
	logic op_tick;
	logic cnt_tick;
	logic rise;
	logic fall;
	logic both;
	logic valid_edge;
	logic sw_start;
	logic stop0;
	logic trig;
	logic start_evt;
	logic cap_evt;
	tcsc_pkg::tcsc_fn_t fn;

	// ************************************************************
	// decode of configuration and pin edges
	// ************************************************************
	// the clock gate freezes counting, starts and captures; the bus stays usable
	assign gate_on = q.gate[tcsc_pkg::GATE_EN_BIT];
	assign bus_req = wb_req.cyc & wb_req.stb;
	assign wr = q.ack & bus_req & wb_req.we;
	assign be16 = {{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
	assign prs_a = q.presc_sel[tcsc_pkg::PRSA_LO +: 4];
	assign prs_b = q.presc_sel[tcsc_pkg::PRSB_LO +: 4];
	// power-of-two division: tick when the low prs bits are all ones
	assign mask_a = 15'((16'h0001 << prs_a) - 16'h0001);
	assign mask_b = 15'((16'h0001 << prs_b) - 16'h0001);
	assign tick_a = gate_on & ((q.presc & mask_a) == mask_a);
	assign tick_b = gate_on & ((q.presc & mask_b) == mask_b);
	assign op_tick = q.mode[tcsc_pkg::CKS_HI] ? tick_b : tick_a;
	assign rise = q.pin_s2 & ~q.pin_prev;
	assign fall = ~q.pin_s2 & q.pin_prev;
	assign both = rise | fall;
	assign cnt_tick = q.mode[tcsc_pkg::CCS_BIT] ? valid_edge : op_tick;
	assign sw_start = wr && wb_req.adr == tcsc_pkg::OFS_START
		&& wb_req.sel[0] && wb_req.dat[tcsc_pkg::CH0_BIT];
	assign stop0 = wr && wb_req.adr == tcsc_pkg::OFS_STOP
		&& wb_req.sel[0] && wb_req.dat[tcsc_pkg::CH0_BIT];

	// valid edge of the capture input
	always_comb begin
		unique case (q.mode[tcsc_pkg::EDGE_LO +: 2])
			tcsc_pkg::EDGE_FALL: valid_edge = gate_on & fall;
			tcsc_pkg::EDGE_RISE: valid_edge = gate_on & rise;
			default: valid_edge = gate_on & both;
		endcase
	end

	// start trigger source; unlisted codes fall back to software only
	always_comb begin
		unique case (q.mode[tcsc_pkg::TRIG_LO +: 3])
			tcsc_pkg::TRIG_EDGE: trig = valid_edge;
			tcsc_pkg::TRIG_BOTH: trig = gate_on & both;
			tcsc_pkg::TRIG_MASTER: trig = gate_on & master_irq_in;
			default: trig = sw_start;
		endcase
	end

	// channel function from the mode field
	always_comb begin
		unique case (q.mode[tcsc_pkg::MODE_LO +: 4])
			tcsc_pkg::MD_CAP0, tcsc_pkg::MD_CAP1: fn = tcsc_pkg::FN_CAPTURE;
			tcsc_pkg::MD_EVT: fn = tcsc_pkg::FN_EVENT;
			tcsc_pkg::MD_ONE0, tcsc_pkg::MD_ONE1: fn = tcsc_pkg::FN_ONE;
			tcsc_pkg::MD_CAPONE: fn = tcsc_pkg::FN_CAPONE;
			default: fn = tcsc_pkg::FN_INTERVAL;
		endcase
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_q = q;
		start_evt = 1'b0;
		cap_evt = 1'b0;
		// synchroniser: first stage is read only by the second
		next_q.pin_s1 = capture_input_pin;
		next_q.pin_s2 = q.pin_s1;
		next_q.pin_prev = q.pin_s2;
		next_q.irq = 1'b0;
		next_q.stop_pulse = 16'h0000;
		// registered ack, dropped the cycle after it is given
		next_q.ack = bus_req & ~q.ack;
		if (bus_req & ~q.ack) begin
			unique case (wb_req.adr)
				tcsc_pkg::OFS_GATE: next_q.rdata = {24'h000000, q.gate};
				tcsc_pkg::OFS_PRESC: next_q.rdata = {16'h0000, q.presc_sel};
				tcsc_pkg::OFS_MODE: next_q.rdata = {16'h0000, q.mode};
				tcsc_pkg::OFS_COUNT: next_q.rdata = {16'h0000, q.cnt};
				tcsc_pkg::OFS_DATA: next_q.rdata = {16'h0000, q.data};
				tcsc_pkg::OFS_STATUS: next_q.rdata = {30'h0000000,
					q.ch == tcsc_pkg::CH_RUN, q.ch != tcsc_pkg::CH_OFF};
				default: next_q.rdata = 32'h00000000; // write-only or unmapped
			endcase
		end
		// register writes take effect at the acknowledging edge
		if (wr) begin
			unique case (wb_req.adr)
				tcsc_pkg::OFS_GATE: if (wb_req.sel[0]) begin
					next_q.gate = wb_req.dat[7:0] & tcsc_pkg::GATE_MASK;
				end
				tcsc_pkg::OFS_PRESC: next_q.presc_sel = (q.presc_sel & ~be16)
					| (wb_req.dat[15:0] & be16 & tcsc_pkg::PRESC_MASK);
				tcsc_pkg::OFS_MODE: next_q.mode = (q.mode & ~be16)
					| (wb_req.dat[15:0] & be16 & tcsc_pkg::MODE_MASK);
				tcsc_pkg::OFS_DATA: next_q.data = (q.data & ~be16)
					| (wb_req.dat[15:0] & be16);
				tcsc_pkg::OFS_STOP: next_q.stop_pulse =
					wb_req.dat[15:0] & be16 & tcsc_pkg::STOP_MASK;
				default: ;
			endcase
		end
		// prescaler runs only while the unit clock is supplied
		if (gate_on) begin
			next_q.presc = q.presc + 15'h0001;
		end
		// channel 0; everything but stop freezes while the clock is gated
		if (gate_on) begin
			unique case (q.ch)
				tcsc_pkg::CH_OFF: begin
					if (sw_start) begin
						start_evt = (fn != tcsc_pkg::FN_ONE)
							&& (fn != tcsc_pkg::FN_CAPONE);
						next_q.ch = start_evt ? tcsc_pkg::CH_RUN
							: tcsc_pkg::CH_WAIT;
					end
				end
				tcsc_pkg::CH_WAIT: begin
					// one-shot modes wait here for their trigger
					if (trig) begin
						start_evt = 1'b1;
						next_q.ch = tcsc_pkg::CH_RUN;
					end
				end
				tcsc_pkg::CH_RUN: begin
					unique case (fn)
						tcsc_pkg::FN_CAPTURE: begin
							if (valid_edge) begin
								cap_evt = 1'b1;
							end else if (cnt_tick) begin
								next_q.cnt = q.cnt + 16'h0001;
							end
						end
						tcsc_pkg::FN_CAPONE: begin
							// starts are ignored while running
							if (valid_edge) begin
								cap_evt = 1'b1;
								next_q.ch = tcsc_pkg::CH_WAIT;
							end else if (op_tick) begin
								next_q.cnt = q.cnt + 16'h0001;
							end
						end
						tcsc_pkg::FN_ONE: begin
							if (trig && q.mode[tcsc_pkg::MODE_LO]) begin
								start_evt = 1'b1; // restart allowed
							end else if (cnt_tick) begin
								// code 1000 ignores trig here
								if (q.cnt == 16'h0000) begin
									next_q.irq = 1'b1;
									next_q.ch = tcsc_pkg::CH_WAIT;
								end else begin
									next_q.cnt = q.cnt - 16'h0001;
								end
							end
						end
						default: begin
							// interval and event: count down, reload at zero
							if (sw_start) begin
								start_evt = 1'b1;
							end else if ((fn == tcsc_pkg::FN_EVENT ? valid_edge
								: cnt_tick)) begin
								if (q.cnt == 16'h0000) begin
									next_q.irq = 1'b1;
									next_q.cnt = q.data;
								end else begin
									next_q.cnt = q.cnt - 16'h0001;
								end
							end
						end
					endcase
				end
				default: next_q.ch = tcsc_pkg::CH_OFF;
			endcase
			if (cap_evt) begin
				next_q.data = q.cnt;
				next_q.cnt = 16'h0000;
				next_q.irq = 1'b1;
			end
			// a start never raises the interrupt
			if (start_evt) begin
				next_q.irq = 1'b0;
				next_q.cnt = (fn == tcsc_pkg::FN_CAPTURE
					|| fn == tcsc_pkg::FN_CAPONE) ? 16'h0000 : q.data;
			end
		end
		// stop wins over the state and interrupt of a same-cycle start or count; their counter update still lands
		if (stop0) begin
			next_q.ch = tcsc_pkg::CH_OFF;
			next_q.irq = 1'b0;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			q.ack <= 1'b0;
			q.rdata <= 32'h00000000;
			q.gate <= tcsc_pkg::GATE_RST;
			q.presc_sel <= tcsc_pkg::PRESC_RST;
			q.mode <= tcsc_pkg::MODE_RST;
			q.data <= tcsc_pkg::DATA_RST;
			q.cnt <= 16'h0000;
			q.presc <= 15'h0000;
			q.ch <= tcsc_pkg::CH_OFF;
			q.irq <= 1'b0;
			q.stop_pulse <= 16'h0000;
			q.pin_s1 <= 1'b0;
			q.pin_s2 <= 1'b0;
			q.pin_prev <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

	assign wb_rsp.ack = q.ack;
	assign wb_rsp.dat = q.rdata;
	assign timer_unit_clock_enable = gate_on;
	assign ch0_timer_irq = q.irq;
	assign stop_trigger_pulse = q.stop_pulse;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_stop_write;
		wr && wb_req.adr == tcsc_pkg::OFS_STOP && wb_req.sel[0]
			&& wb_req.dat[0];
	endsequence
	sequence s_pulse_once;
		stop_trigger_pulse[0] ##1 !stop_trigger_pulse[0];
	endsequence

	a_gate_freezes_count: assert property (
		!gate_on && !$past(gate_on) |-> $stable(q.cnt) && !ch0_timer_irq
	) else $error("counter moved while clock gated");
	a_prescale_div1: assert property (
		gate_on && prs_a == 4'h0 |-> tick_a
	) else $error("prescale 0 missed a tick");
	a_prescale_div2: assert property (
		tick_a && prs_a == 4'h1 && $stable(prs_a) |=> !tick_a
	) else $error("prescale 1 ticked twice");
	a_stop_halts_ch: assert property (
		s_stop_write |=> q.ch == tcsc_pkg::CH_OFF && !ch0_timer_irq
	) else $error("stop did not halt channel");
	a_stop_pulse_seq: assert property (
		s_stop_write |=> s_pulse_once
	) else $error("stop pulse not single");
	a_mode_zero_bits: assert property (
		(q.mode & ~tcsc_pkg::MODE_MASK) == 16'h0000
			&& (q.presc_sel & ~tcsc_pkg::PRESC_MASK) == 16'h0000
	) else $error("reserved bits not zero");
	a_start_no_irq: assert property (
		start_evt && !stop0 |=> !ch0_timer_irq
	) else $error("interrupt at start");
	a_capture_copies: assert property (
		cap_evt && !stop0 |=> q.data == $past(q.cnt) && q.cnt == 16'h0000
			&& ch0_timer_irq
	) else $error("capture did not copy and clear");
	a_oneshot_ignore: assert property (
		q.ch == tcsc_pkg::CH_RUN && fn == tcsc_pkg::FN_ONE
			&& !q.mode[0] |-> !start_evt
	) else $error("mode 1000 took a restart");
	a_ack_single: assert property (
		q.ack |=> !q.ack
	) else $error("ack held two cycles");
	// the reload must use the data value that stood at the zero tick
	a_interval_reload: assert property (
		q.ch == tcsc_pkg::CH_RUN && fn == tcsc_pkg::FN_INTERVAL && cnt_tick
			&& q.cnt == 16'h0000 && !sw_start && !stop0
			|=> ch0_timer_irq && q.cnt == $past(q.data)
	) else $error("interval did not reload at zero");
	a_oneshot_end: assert property (
		q.ch == tcsc_pkg::CH_RUN && fn == tcsc_pkg::FN_ONE && cnt_tick
			&& q.cnt == 16'h0000 && !trig && !stop0
			|=> ch0_timer_irq && q.ch == tcsc_pkg::CH_WAIT
	) else $error("one-count did not end at zero");
	// a taken restart would clear the count instead of advancing it
	a_capone_keeps_count: assert property (
		q.ch == tcsc_pkg::CH_RUN && fn == tcsc_pkg::FN_CAPONE && op_tick
			&& !valid_edge && !stop0 |=> q.cnt == $past(q.cnt) + 16'h0001
	) else $error("capture one-count count disturbed");
endmodule
`default_nettype wire

// [tb/tb_timer_channel_setup_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel_setup_control;
	logic mclk;
	logic nrst;
	tcsc_pkg::tcsc_wb_req_t wb_req;
	tcsc_pkg::tcsc_wb_rsp_t wb_rsp;
	logic pin;
	logic go;
	logic master_irq_in;
	logic clk_en;
	logic irq;
	logic [15:0] stop_pulse;
	logic [15:0] last_stop;
	logic [31:0] last_dat;
	logic [31:0] rv;
	logic [32:0] note;
	logic [32:0] exp_q[$];
	logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hC};
	int miscompares;
	int tests_run;
	int irq_n;
	int irq_t;
	int cyc_n;
	int base;
	int t0;
	int got;
	// ****************************************************************
	// clock, design and far side
	// ****************************************************************
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	tcsc_top dut_u (.mclk(mclk), .nrst(nrst), .wb_req(wb_req),
		.wb_rsp(wb_rsp), .capture_input_pin(pin),
		.master_irq_in(master_irq_in), .timer_unit_clock_enable(clk_en),
		.ch0_timer_irq(irq), .stop_trigger_pulse(stop_pulse));
	tcsc_pulse_src src_u (.mclk(mclk), .nrst(nrst), .go(go),
		.half(16'h0014), .pin(pin));
	// ****************************************************************
	// checking and bus tasks
	// ****************************************************************
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test;
		if (miscompares == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// one classic cycle; called just after an edge, ends just after one
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] n);
		exp_q.push_back(n);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		do @(posedge mclk); while (wb_rsp.ack !== 1'b1);
		wb_req.cyc <= 1'b0;
		wb_req.stb <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 33'h000000000);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h00000000, {1'b1, e});
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// watcher: read data against the oldest note, plus event tallies
	always @(posedge mclk) begin
		cyc_n++;
		if (irq === 1'b1) begin
			irq_n++;
			irq_t = cyc_n;
		end
		if (stop_pulse !== 16'h0000) last_stop = stop_pulse;
		if (wb_rsp.ack === 1'b1 && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			last_dat = wb_rsp.dat;
			if (note[32]) check("read data", wb_rsp.dat, note[31:0]);
		end
	end
	// hang guard, generous over the roughly 1350 cycles of the sequence
	initial begin
		idle(20000);
		miscompares++;
		end_of_test;
	end
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		void'($urandom(30));
		nrst = 1'b0;
		wb_req = '0;
		go = 1'b0;
		master_irq_in = 1'b0;
		last_stop = 16'h0000;
		idle(10);
		nrst <= 1'b1;
		idle(1);
		rd(tcsc_pkg::OFS_PRESC, {16'h0000, tcsc_pkg::PRESC_RST});
		rd(tcsc_pkg::OFS_MODE, {16'h0000, tcsc_pkg::MODE_RST});
		wr(tcsc_pkg::OFS_GATE, 32'h000000FF);
		rd(tcsc_pkg::OFS_GATE, {24'h000000, tcsc_pkg::GATE_MASK});
		check("clock enable on", {31'h0, clk_en}, 32'h1);
		wr(tcsc_pkg::OFS_GATE, 32'h00000000);
		check("clock enable off", {31'h0, clk_en}, 32'h0);
		rv = $urandom;
		wr(tcsc_pkg::OFS_PRESC, rv);
		rd(tcsc_pkg::OFS_PRESC, {16'h0, rv[15:0] & tcsc_pkg::PRESC_MASK});
		// every mode code survives with random upper fields, holes read 0
		for (int i = 0; i < 8; i++) begin
			rv = $urandom;
			rv[3:0] = codes[i];
			wr(tcsc_pkg::OFS_MODE, rv);
			rd(tcsc_pkg::OFS_MODE, {16'h0, rv[15:0] & tcsc_pkg::MODE_MASK});
		end
		wr(tcsc_pkg::OFS_STOP, 32'h0000FFFF);
		// the watcher notes the pulse at this very edge; let it land
		idle(1);
		check("stop pulses", {16'h0, last_stop}, 32'h00000AFF);
		last_stop = 16'h0000;
		wr(tcsc_pkg::OFS_STOP, 32'h00000000);
		check("stop on zero", {16'h0, last_stop}, 32'h0);
		rd(tcsc_pkg::OFS_STOP, 32'h00000000);
		rd(8'h20, 32'h00000000);
		// started while the unit clock is off: edges must not capture
		wr(tcsc_pkg::OFS_PRESC, 32'h00000000);
		wr(tcsc_pkg::OFS_MODE, 32'h00000144);
		wr(tcsc_pkg::OFS_START, 32'h00000001);
		go <= 1'b1;
		base = irq_n;
		idle(200);
		check("gated irq", irq_n - base, 32'h0);
		go <= 1'b0;
		// capture on rising edges, set up in the required order
		wr(tcsc_pkg::OFS_GATE, 32'h00000001);
		wr(tcsc_pkg::OFS_PRESC, 32'h00000000);
		wr(tcsc_pkg::OFS_STOP, 32'h00000001);
		wr(tcsc_pkg::OFS_MODE, 32'h00000144);
		base = irq_n;
		wr(tcsc_pkg::OFS_START, 32'h00000001);
		idle(10);
		check("start irq", irq_n - base, 32'h0);
		go <= 1'b1;
		idle(200);
		check("capture irqs", {31'h0, (irq_n - base) >= 4}, 32'h1);
		wb(1'b0, tcsc_pkg::OFS_DATA, 32'h0, 33'h0);
		// one period is 40 ticks; allow one tick of edge skew
		check("period", {31'h0, last_dat >= 39 && last_dat <= 41}, 32'h1);
		wr(tcsc_pkg::OFS_STOP, 32'h00000001);
		idle(2);
		base = irq_n;
		idle(160);
		check("stopped irq", irq_n - base, 32'h0);
		go <= 1'b0;
		// one-count from 30: arm, trigger, restart 10 cycles in; 1001 only
		for (int m = 8; m < 10; m++) begin
			wr(tcsc_pkg::OFS_MODE, m);
			wr(tcsc_pkg::OFS_DATA, 32'h0000001E);
			base = irq_n;
			wr(tcsc_pkg::OFS_START, 32'h00000001);
			wr(tcsc_pkg::OFS_START, 32'h00000001); // trigger
			t0 = cyc_n;
			idle(8);
			wr(tcsc_pkg::OFS_START, 32'h00000001);
			idle(80);
			check("one-count irq", {31'h0, irq_n > base}, 32'h1);
			check("restart", {31'h0, irq_t - t0 > 36}, m - 8);
			wr(tcsc_pkg::OFS_STOP, 32'h00000001);
		end
		// interval from 9: one interrupt per 10 ticks; 0011 is reserved
		for (int k = 0; k < 2; k++) begin
			wr(tcsc_pkg::OFS_MODE, k * 3);
			wr(tcsc_pkg::OFS_DATA, 32'h00000009);
			base = irq_n;
			wr(tcsc_pkg::OFS_START, 32'h00000001);
			idle(100);
			got = irq_n - base;
			check("interval irqs", {31'h0, got >= 9 && got <= 11}, 32'h1);
			wr(tcsc_pkg::OFS_STOP, 32'h00000001);
		end
		// capture with one-count, armed, then started by the master pulse;
		// a second master pulse while counting must not clear the count
		wr(tcsc_pkg::OFS_MODE, 32'h0000044C);
		base = irq_n;
		wr(tcsc_pkg::OFS_START, 32'h00000001);
		master_irq_in <= 1'b1;
		idle(1);
		master_irq_in <= 1'b0;
		idle(5);
		master_irq_in <= 1'b1;
		idle(1);
		master_irq_in <= 1'b0;
		go <= 1'b1;
		idle(200);
		check("one capture", irq_n - base, 32'h1);
		// 28 ticks from the first master pulse to the first rising edge
		rd(tcsc_pkg::OFS_DATA, 32'h0000001C);
		go <= 1'b0;
		end_of_test;
	end
endmodule
`default_nettype wire

// [tb/tcsc_pulse_src.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// far side: pulse source on the capture pin
// ****************************************************************
module tcsc_pulse_src (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic go,
	input wire logic [15:0] half,
	output logic pin
);
	logic [15:0] cnt;
	// square wave of period 2*half while enabled; held low when idle,
	// as a board pull-down would, so no stale level leaks into a frame
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 16'h0000;
			pin <= 1'b0;
		end else if (!go) begin
			cnt <= 16'h0000;
			pin <= 1'b0;
		end else if (cnt == half - 16'h0001) begin
			cnt <= 16'h0000;
			pin <= ~pin; // rising edge starts each period
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
endmodule
`default_nettype wire
